// File: include/synth_cfg_pkg.sv
package synth_cfg_pkg;

  // ----------------------------------------------------------------
  // Bus and register geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_W = 24;
  localparam logic [ADDR_W-1:0] OFS_MOD = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_FS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PWR = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_LF = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_MOD = 24'h000000;
  localparam logic [REG_W-1:0] RST_FS = 24'h000000;
  localparam logic [REG_W-1:0] RST_PWR = 24'h000000;
  localparam logic [REG_W-1:0] RST_LF = 24'h000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MOD_SPREAD_LSB = 0;
  localparam int MOD_WIDE_BIT = 2;
  localparam int MOD_HALVE_BIT = 3;
  localparam int FS_TMO_LSB = 0;
  localparam int FS_FPUMP_LSB = 14;
  localparam int FS_SPUMP_LSB = 18;
  localparam int PWR_EN_LSB = 0;
  localparam int PWR_RST_BIT = 7;
  localparam int LF_CAP_LSB = 0;
  localparam int LF_R3F_LSB = 3;
  localparam int LF_RES3_LSB = 5;
  localparam int LF_R4F_LSB = 7;
  localparam int LF_RES4_LSB = 9;

  // ----------------------------------------------------------------
  // Codes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SPREAD_WEAK = 2'h0;
  localparam logic [1:0] SPREAD_STRONG = 2'h2;
  localparam logic [1:0] SPREAD_NONE = 2'h3;
  localparam logic [13:0] TMO_HIZ = 14'h0000;
  localparam logic [13:0] TMO_ALWAYS = 14'h0001;
  localparam logic [13:0] TMO_LOW = 14'h0002;
  localparam logic [13:0] TMO_HIGH = 14'h0003;
  localparam logic [5:0] RES_STEP_KOHM = 6'h0A;
  localparam int NARROW_BITS = 12;

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_COUNT = 2'b01,
    FS_HOLD = 2'b11
  } fs_state_e;

  typedef struct packed {
    logic spread_weak;
    logic spread_strong;
    logic spread_off;
    logic wide_denominator_select;
    logic output_halver;
    logic [21:0] frac_num_eff;
    logic [21:0] frac_den_eff;
    logic fast_active;
    logic [3:0] pump_code;
    logic [4:0] pump_mult;
    logic [6:0] power_en;
    logic [7:0] cap3_pf;
    logic [7:0] cap4_pf;
    logic [5:0] res3_kohm;
    logic [5:0] res4_kohm;
  } synth_ctrl_s;

endpackage

// File: logic/synth_config_fast_settle.sv
module synth_config_fast_settle
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rdata,
  input wire logic [21:0] frac_num_in,
  input wire logic [21:0] frac_den_in,
  input wire logic freq_programmed,
  input wire logic pd_tick,
  input wire logic fast_settle_pin_in,
  output logic fast_settle_pin_out,
  output logic fast_settle_pin_oe,
  output synth_ctrl_s ctrl
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [REG_W-1:0] modulator_divider_config_reg;
  logic [REG_W-1:0] fast_settle_config_reg;
  logic [REG_W-1:0] power_and_reset_control_reg;
  logic [REG_W-1:0] loop_filter_config_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0] pin_in_reg;

  logic defaults_hold;
  logic [13:0] timeout_code;
  logic wr_mod;
  logic wr_fs;
  logic wr_pwr;
  logic wr_lf;

  assign defaults_hold = power_and_reset_control_reg[PWR_RST_BIT];
  assign timeout_code = fast_settle_config_reg[FS_TMO_LSB +: 14];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_mod = 1'b0;
    wr_fs = 1'b0;
    wr_pwr = 1'b0;
    wr_lf = 1'b0;
    if (wr_stb && addr == OFS_MOD) begin
      wr_mod = 1'b1;
    end else if (wr_stb && addr == OFS_FS) begin
      wr_fs = 1'b1;
    end else if (wr_stb && addr == OFS_PWR) begin
      wr_pwr = 1'b1;
    end else if (wr_stb && addr == OFS_LF) begin
      wr_lf = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // defaults-reset clears the modulator, fast-settle and loop-filter registers
  // While held, other writes are dropped so defaults stay in place.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modulator_divider_config_reg <= RST_MOD;
      fast_settle_config_reg <= RST_FS;
      loop_filter_config_reg <= RST_LF;
    end else if (wr_pwr && wdata[PWR_RST_BIT]) begin
      modulator_divider_config_reg <= RST_MOD;
      fast_settle_config_reg <= RST_FS;
      loop_filter_config_reg <= RST_LF;
    end else if (!defaults_hold) begin
      if (wr_mod) begin
        modulator_divider_config_reg <= wdata[REG_W-1:0];
      end
      if (wr_fs) begin
        fast_settle_config_reg <= wdata[REG_W-1:0];
      end
      if (wr_lf) begin
        loop_filter_config_reg <= wdata[REG_W-1:0];
      end
    end
  end

  // powered down on reset
  // Release write keeps defaults; a third write sets the enables.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_and_reset_control_reg <= RST_PWR;
    end else if (wr_pwr && wdata[PWR_RST_BIT]) begin
      power_and_reset_control_reg <= RST_PWR | (REG_W'(1) << PWR_RST_BIT);
    end else if (wr_pwr && defaults_hold) begin
      power_and_reset_control_reg <= RST_PWR;
    end else if (wr_pwr) begin
      power_and_reset_control_reg <= wdata[REG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Fast-settle timer
  // ----------------------------------------------------------------
  fs_state_e fs_state_reg;
  fs_state_e fs_state_next;
  logic [14:0] fs_count_reg;
  logic [14:0] fs_count_next;

  always_comb begin
    fs_state_next = fs_state_reg;
    fs_count_next = fs_count_reg;
    case (fs_state_reg)
      FS_IDLE: begin
        if (freq_programmed && timeout_code == TMO_ALWAYS) begin
          fs_state_next = FS_HOLD;
        end else if (freq_programmed && timeout_code > TMO_HIGH) begin
          fs_count_next = {timeout_code, 1'b0};
          fs_state_next = FS_COUNT;
        end
      end
      FS_COUNT: begin
        if (timeout_code <= TMO_HIGH) begin
          fs_count_next = 15'h0000;
          fs_state_next = (timeout_code == TMO_ALWAYS) ? FS_HOLD : FS_IDLE;
        end else if (freq_programmed) begin
          fs_count_next = {timeout_code, 1'b0};
        end else if (pd_tick) begin
          fs_count_next = fs_count_reg - 15'h0001;
          if (fs_count_reg == 15'h0001) begin
            fs_state_next = FS_IDLE;
          end
        end
      end
      FS_HOLD: begin
        if (timeout_code != TMO_ALWAYS) begin
          fs_state_next = FS_IDLE;
        end
      end
      default: begin
        fs_state_next = FS_IDLE;
        fs_count_next = 15'h0000;
      end
    endcase
    if (defaults_hold || wr_pwr && wdata[PWR_RST_BIT]) begin
      fs_state_next = FS_IDLE;
      fs_count_next = 15'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fs_state_reg <= FS_IDLE;
      fs_count_reg <= 15'h0000;
    end else begin
      fs_state_reg <= fs_state_next;
      fs_count_reg <= fs_count_next;
    end
  end

  // ----------------------------------------------------------------
  // Fast-settle pin
  // ----------------------------------------------------------------
  // pin by code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_settle_pin_out <= 1'b0;
      fast_settle_pin_oe <= 1'b0;
    end else begin
      case (timeout_code)
        TMO_HIZ: begin
          fast_settle_pin_out <= 1'b0;
          fast_settle_pin_oe <= 1'b0;
        end
        TMO_ALWAYS, TMO_LOW: begin
          fast_settle_pin_out <= 1'b0;
          fast_settle_pin_oe <= 1'b1;
        end
        TMO_HIGH: begin
          fast_settle_pin_out <= 1'b1;
          fast_settle_pin_oe <= 1'b1;
        end
        default: begin
          fast_settle_pin_out <= 1'b0;
          fast_settle_pin_oe <= (fs_state_next == FS_COUNT);
        end
      endcase
    end
  end

  // Pin level sampled for status only, so general output can be checked.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_in_reg <= 2'b00;
    end else begin
      pin_in_reg <= {pin_in_reg[0], fast_settle_pin_in};
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic fast_now;
  logic [1:0] spread_code;
  logic [3:0] pump_sel;
  logic [1:0] res3_sel;
  logic [1:0] res4_sel;
  logic [7:0] cap3;
  logic [7:0] cap4;

  assign fast_now = (fs_state_next != FS_IDLE);
  assign spread_code = modulator_divider_config_reg[MOD_SPREAD_LSB +: 2];
  assign pump_sel = fast_now ? fast_settle_config_reg[FS_FPUMP_LSB +: 4]
                             : fast_settle_config_reg[FS_SPUMP_LSB +: 4];
  assign res3_sel = fast_now ? loop_filter_config_reg[LF_R3F_LSB +: 2]
                             : loop_filter_config_reg[LF_RES3_LSB +: 2];
  assign res4_sel = fast_now ? loop_filter_config_reg[LF_R4F_LSB +: 2]
                             : loop_filter_config_reg[LF_RES4_LSB +: 2];

  always_comb begin
    case (loop_filter_config_reg[LF_CAP_LSB +: 3])
      3'h0: begin
        cap3 = 8'h32;
        cap4 = 8'h32;
      end
      3'h1: begin
        cap3 = 8'h32;
        cap4 = 8'h64;
      end
      3'h3: begin
        cap3 = 8'h64;
        cap4 = 8'h32;
      end
      3'h4: begin
        cap3 = 8'h96;
        cap4 = 8'h32;
      end
      3'h5: begin
        cap3 = 8'h64;
        cap4 = 8'h64;
      end
      default: begin
        cap3 = 8'h32;
        cap4 = 8'h96;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
    end else begin
      // spread decode
      // Reserved code 1 falls back to no spreading rather than guessing.
      ctrl.spread_weak <= (spread_code == SPREAD_WEAK);
      ctrl.spread_strong <= (spread_code == SPREAD_STRONG);
      ctrl.spread_off <= (spread_code == SPREAD_NONE) || (spread_code == 2'h1);
      ctrl.wide_denominator_select <= modulator_divider_config_reg[MOD_WIDE_BIT];
      ctrl.output_halver <= modulator_divider_config_reg[MOD_HALVE_BIT];
      if (modulator_divider_config_reg[MOD_WIDE_BIT]) begin
        ctrl.frac_num_eff <= frac_num_in;
        ctrl.frac_den_eff <= frac_den_in;
      end else begin
        ctrl.frac_num_eff <= {10'h000, frac_num_in[NARROW_BITS-1:0]};
        ctrl.frac_den_eff <= {10'h000, frac_den_in[NARROW_BITS-1:0]};
      end
      ctrl.fast_active <= fast_now;
      ctrl.pump_code <= pump_sel;
      ctrl.pump_mult <= {1'b0, pump_sel} + 5'h01;
      ctrl.power_en <= power_and_reset_control_reg[PWR_EN_LSB +: 7];
      ctrl.cap3_pf <= cap3;
      ctrl.cap4_pf <= cap4;
      ctrl.res3_kohm <= 6'(({4'h0, res3_sel} + 6'h01) * RES_STEP_KOHM);
      ctrl.res4_kohm <= 6'(({4'h0, res4_sel} + 6'h01) * RES_STEP_KOHM);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (addr == OFS_MOD) begin
      rdata_next = {8'h00, modulator_divider_config_reg};
    end else if (addr == OFS_FS) begin
      rdata_next = {8'h00, fast_settle_config_reg};
    end else if (addr == OFS_PWR) begin
      rdata_next = {8'h00, power_and_reset_control_reg};
    end else if (addr == OFS_LF) begin
      rdata_next = {8'h00, loop_filter_config_reg};
    end else if (addr == OFS_STAT) begin
      rdata_next = {12'h000, pin_in_reg[1], defaults_hold, fs_state_reg, fs_count_reg, 1'b0};
    end
  end

  // Data stand for one cycle only, zero otherwise.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_stb ? rdata_next : '0;
    end
  end

  assign rdata = rdata_reg;

endmodule // synth_config_fast_settle

// File: tb/host_model.sv
module host_model
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Host bus cycles
  // ----------------------------------------------------------------
  logic init_done;
  initial begin
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    init_done = 1'b0;
  end
  task automatic write(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= {8'h00, v};
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Data stands one cycle only, so it is taken just after the edge
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic init(input logic [6:0] en);
    if (!init_done) begin
      write(OFS_PWR, 24'h000080);
      write(OFS_PWR, 24'h000000);
    end
    write(OFS_PWR, {17'h00000, en});
    init_done = 1'b1;
  endtask
endmodule // host_model

// File: tb/synth_config_fast_settle_chk.sv
module synth_cfg_chk
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic [21:0] frac_den_in,
  input wire logic freq_programmed,
  input wire logic pd_tick,
  input wire logic fast_settle_pin_out,
  input wire logic fast_settle_pin_oe,
  input wire synth_ctrl_s ctrl
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // First edge after reset still sees zeros in ctrl
  spread_onehot_a: assert property (
    $past(rst_b) |-> $onehot({ctrl.spread_weak, ctrl.spread_strong, ctrl.spread_off}))
    else $error("spread flags not one-hot");
  den_mask_a: assert property (
    $past(rst_b) |-> ctrl.frac_den_eff == (ctrl.wide_denominator_select ?
      $past(frac_den_in) : ($past(frac_den_in) & 22'h000FFF)))
    else $error("denominator width wrong");
  fast_drive_a: assert property (
    ctrl.fast_active |-> fast_settle_pin_oe && !fast_settle_pin_out)
    else $error("pin not grounded in fast-settle");
  pump_mult_a: assert property (
    $past(rst_b) |-> ctrl.pump_mult == {1'b0, ctrl.pump_code} + 5'h01)
    else $error("pump multiple wrong");
  res_legal_a: assert property (
    $past(rst_b) |-> ctrl.res3_kohm inside {6'h0A, 6'h14, 6'h1E, 6'h28}
      && ctrl.res4_kohm inside {6'h0A, 6'h14, 6'h1E, 6'h28})
    else $error("resistor value off table");
  defaults_off_a: assert property (
    wr_stb && addr == OFS_PWR && wdata[PWR_RST_BIT] |-> ##2 ctrl.power_en == 7'h00)
    else $error("defaults reset left power on");
  fast_start_a: assert property (
    $rose(ctrl.fast_active) |-> $past(freq_programmed) || $past(freq_programmed, 2))
    else $error("fast-settle began unprompted");
  fast_end_a: assert property (
    $fell(ctrl.fast_active) |-> $past(pd_tick) || $past(pd_tick, 2) || $past(wr_stb)
      || $past(wr_stb, 2) || $past(wr_stb, 3))
    else $error("fast-settle ended without cause");
endmodule // synth_cfg_chk

bind synth_config_fast_settle synth_cfg_chk i_chk (
  .clk, .rst_b, .addr, .wdata, .wr_stb, .frac_den_in, .freq_programmed, .pd_tick,
  .fast_settle_pin_out, .fast_settle_pin_oe, .ctrl
);

// File: tb/synth_config_fast_settle_tb.sv
module synth_config_fast_settle_tb
  import synth_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_b;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [DATA_W-1:0] rdata;
  logic [21:0] frac_num_in;
  logic [21:0] frac_den_in;
  logic freq_programmed;
  logic pd_tick;
  logic pin_out;
  logic pin_oe;
  synth_ctrl_s ctrl;
  logic [DATA_W-1:0] d;
  int mismatches;
  int num_checks;
  int cycles;
  logic [7:0] c3_tab [8] = '{8'h32, 8'h32, 8'h32, 8'h64, 8'h96, 8'h64, 8'h32, 8'h32};
  logic [7:0] c4_tab [8] = '{8'h32, 8'h64, 8'h96, 8'h32, 8'h32, 8'h64, 8'h96, 8'h96};
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  // Released pin shows the inverse, so a stale level cannot pass
  synth_config_fast_settle i_dut (
    .clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .frac_num_in, .frac_den_in,
    .freq_programmed, .pd_tick, .fast_settle_pin_in(pin_oe ? pin_out : !pin_out),
    .fast_settle_pin_out(pin_out), .fast_settle_pin_oe(pin_oe), .ctrl
  );
  host_model i_host (.clk, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic tick);
    @(posedge clk);
    pd_tick <= tick;
    freq_programmed <= !tick;
    @(posedge clk);
    pd_tick <= 1'b0;
    freq_programmed <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    frac_num_in = 22'h3FFFFF;
    frac_den_in = 22'h2ABCDE;
    freq_programmed = 1'b0;
    pd_tick = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    i_host.init(7'h7F);
    settle();
    check("power_en", ctrl.power_en, 7'h7F);
    for (int i = 0; i < 3; i++) begin
      i_host.write(OFS_MOD, {20'h00000, i[0], i[0], (i == 0) ? 2'h0 : 2'(i + 1)});
      settle();
      check("spread", {ctrl.spread_weak, ctrl.spread_strong, ctrl.spread_off}, 3'b100 >> i);
      check("halver", ctrl.output_halver, i[0]);
      check("den", ctrl.frac_den_eff, i[0] ? 22'h2ABCDE : 22'h000CDE);
      check("num", ctrl.frac_num_eff, i[0] ? 22'h3FFFFF : 22'h000FFF);
    end
    // Reserved code must fall back to no spreading
    i_host.write(OFS_MOD, 24'h000001);
    settle();
    check("spread", {ctrl.spread_weak, ctrl.spread_strong, ctrl.spread_off}, 3'b001);
    for (int i = 0; i < 8; i++) begin
      i_host.write(OFS_LF, {13'h0000, ~i[1:0], 2'h3, i[1:0], 2'h3, 3'(i)});
      settle();
      check("cap3", ctrl.cap3_pf, c3_tab[i]);
      check("cap4", ctrl.cap4_pf, c4_tab[i]);
      check("res3", ctrl.res3_kohm, (i % 4 + 1) * 10);
      check("res4", ctrl.res4_kohm, (4 - i % 4) * 10);
    end
    i_host.write(OFS_FS, 24'h0BC004);
    settle();
    check("pin_oe", pin_oe, 1'b0);
    check("pump", ctrl.pump_mult, 5'h03);
    pulse(1'b0);
    settle();
    check("active", ctrl.fast_active, 1'b1);
    check("pump", ctrl.pump_mult, 5'h10);
    check("res4", ctrl.res4_kohm, 6'h28);
    check("pin", {pin_oe, pin_out}, 2'h2);
    i_host.read(OFS_STAT, d);
    check("status", d, 32'h00010010);
    repeat (7) pulse(1'b1);
    settle();
    check("active", ctrl.fast_active, 1'b1);
    pulse(1'b1);
    settle();
    check("active", ctrl.fast_active, 1'b0);
    check("pin_oe", pin_oe, 1'b0);
    check("res4", ctrl.res4_kohm, 6'h0A);
    // Released pin reads back inverted, so bit 19 proves high-Z
    i_host.read(OFS_STAT, d);
    check("status", d, 32'h00080000);
    for (int i = 0; i < 4; i++) begin
      i_host.write(OFS_FS, 24'(i));
      pulse(1'b0);
      settle();
      check("pin_oe", pin_oe, i != 0);
      check("pin_high", pin_oe && pin_out, i == 3);
      check("active", ctrl.fast_active, i == 1);
    end
    i_host.write(OFS_PWR, 24'h000080);
    i_host.write(OFS_MOD, 24'h000003);
    settle();
    check("power_en", ctrl.power_en, 7'h00);
    check("spread_weak", ctrl.spread_weak, 1'b1);
    i_host.read(OFS_LF, d);
    check("lf_reg", d, 32'h0);
    i_host.write(OFS_PWR, 24'h00007F);
    i_host.init(7'h15);
    settle();
    check("power_en", ctrl.power_en, 7'h15);
    i_host.read(5'h14, d);
    check("unmapped", d, 32'h0);
    final_report();
  end
endmodule // synth_config_fast_settle_tb
